/* File: pkg/eesc_pkg.sv */
/*
 * constants, register map and pin carrier of the encoder and edge-separation counter.
 * assumes an apb master with 32-bit data and one clock, pclk, for all of the logic.
 */
package eesc_pkg;

	// ************************************************
	// register offsets
	// ************************************************
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_RELOAD = 8'h04;
	localparam logic [7:0] REG_COUNT = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;
	localparam logic [7:0] REG_RESULT = 8'h10;

	// ************************************************
	// control fields
	// ************************************************
	localparam int CTRL_ARM = 0;
	localparam int CTRL_SEP = 1;
	localparam int CTRL_DEC_LO = 2;
	localparam int CTRL_BUFPOS = 4;
	localparam int CTRL_SMODE_LO = 5;
	localparam int CTRL_PHASE_LO = 7;
	localparam int CTRL_ZEN = 9;
	localparam int CTRL_TB_FALL = 10;
	localparam int CTRL_START_FALL = 11;
	localparam int CTRL_GATE_FALL = 12;
	localparam int CTRL_SAMP_FALL = 13;
	localparam int CTRL_W = 14;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 14'h0000;

	// ************************************************
	// status fields
	// ************************************************
	localparam int STAT_OVERRUN = 0;
	localparam int STAT_DONE = 1;
	localparam int STAT_FULL = 2;
	localparam int STAT_EMPTY = 3;
	localparam int STAT_LOST = 4;

	// decoding selections
	localparam logic [1:0] single_edge_decoding = 2'h0;
	localparam logic [1:0] double_edge_decoding = 2'h1;
	localparam logic [1:0] quad_edge_decoding = 2'h2;
	localparam logic [1:0] two_pulse_decoding = 2'h3;

	// edge-separation sub-modes
	localparam logic [1:0] SEP_SINGLE = 2'h0;
	localparam logic [1:0] SEP_IMPLICIT = 2'h1;
	localparam logic [1:0] SEP_SAMPLED = 2'h2;

	typedef enum logic [2:0] {
		ES_IDLE,
		ES_WAIT_START,
		ES_COUNT,
		ES_REARM,
		ES_DONE
	} eesc_sep_state_t;

	typedef struct packed {
		logic enc_a;
		logic enc_b;
		logic enc_z;
		logic start_in;
		logic gate_in;
		logic timebase;
		logic sample_clk;
	} eesc_pins_t;

endpackage : eesc_pkg

/* File: src/eesc_counter.sv */
/*
 * encoder position and two-signal edge-separation counter with apb registers,
 * a small result fifo and a valid/ready stream towards host memory.
 * assumes all pins are asynchronous to pclk and that the stream sink may stall.
 */
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/10ps
module eesc_counter #(
	parameter int CW = 32,
	parameter int DEPTH = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire eesc_pkg::eesc_pins_t pins,
	output logic stream_valid,
	output logic [CW-1:0] stream_data,
	input wire logic stream_ready
);
	import eesc_pkg::*;

	localparam int AW = $clog2(DEPTH);

	// ************************************************
	// state
	// ************************************************
	typedef struct packed {
		eesc_pins_t sync1;
		eesc_pins_t sync2;
		eesc_pins_t prev;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [CTRL_W-1:0] ctrl;
		logic [CW-1:0] reload;
		logic [CW-1:0] count;
		logic [CW-1:0] result;
		logic overrun;
		logic done;
		logic lost;
		eesc_sep_state_t sep;
		logic seen_start;
		logic seen_gate;
		logic pending;
		logic [CW-1:0] pend_val;
		logic [DEPTH-1:0][CW-1:0] mem;
		logic [AW-1:0] wptr;
		logic [AW-1:0] rptr;
		logic [AW:0] level;
		logic svalid;
		logic [CW-1:0] sdata;
	} eesc_state_t;

	eesc_state_t s_q, s_d;

	function automatic logic edge_hit(input logic cur, input logic old, input logic fall);
		edge_hit = fall ? (old & ~cur) : (cur & ~old);
	endfunction : edge_hit

	// returns {step, up}
	function automatic logic [1:0] quad_step(input logic [1:0] dec, input logic a,
		input logic pa, input logic b, input logic pb);
		logic ar, af, br, bf;
		ar = a & ~pa;
		af = ~a & pa;
		br = b & ~pb;
		bf = ~b & pb;
		quad_step = 2'h0;
		case (dec)
			single_edge_decoding: begin
				if (ar & ~b)
					quad_step = 2'h3;
				else if (af & ~b)
					quad_step = 2'h2;
			end
			double_edge_decoding: begin
				if (ar)
					quad_step = {1'b1, ~b};
				else if (af)
					quad_step = {1'b1, b};
			end
			quad_edge_decoding: begin
				// a and b moving in one sample is an illegal transition: no step
				if ((ar | af) & ~(br | bf))
					quad_step = {1'b1, ar ? ~b : b};
				else if ((br | bf) & ~(ar | af))
					quad_step = {1'b1, br ? a : ~a};
			end
			default: begin
				if (ar & ~br)
					quad_step = 2'h3;
				else if (br & ~ar)
					quad_step = 2'h2;
			end
		endcase
	endfunction : quad_step

	// ************************************************
	// decoded controls and edges
	// ************************************************
	logic armed, sep_func, bufpos, zen;
	logic [1:0] dec, smode, phase;
	logic tb_edge, start_edge, gate_edge, samp_edge, reload_hit;
	logic [1:0] step;
	logic apb_done, wr, full, empty;

	always_comb begin
		armed = s_q.ctrl[CTRL_ARM];
		sep_func = s_q.ctrl[CTRL_SEP];
		dec = s_q.ctrl[CTRL_DEC_LO+:2];
		bufpos = s_q.ctrl[CTRL_BUFPOS];
		smode = s_q.ctrl[CTRL_SMODE_LO+:2];
		phase = s_q.ctrl[CTRL_PHASE_LO+:2];
		zen = s_q.ctrl[CTRL_ZEN];
		tb_edge = edge_hit(s_q.sync2.timebase, s_q.prev.timebase,
			s_q.ctrl[CTRL_TB_FALL]);
		start_edge = edge_hit(s_q.sync2.start_in, s_q.prev.start_in,
			s_q.ctrl[CTRL_START_FALL]);
		gate_edge = edge_hit(s_q.sync2.gate_in, s_q.prev.gate_in,
			s_q.ctrl[CTRL_GATE_FALL]);
		samp_edge = edge_hit(s_q.sync2.sample_clk, s_q.prev.sample_clk,
			s_q.ctrl[CTRL_SAMP_FALL]);
		step = quad_step(dec, s_q.sync2.enc_a, s_q.prev.enc_a,
			s_q.sync2.enc_b, s_q.prev.enc_b);
		// phase is the {a, b} level pair; the index is only taken inside it
		reload_hit = zen & s_q.sync2.enc_z & (dec != two_pulse_decoding) &
			({s_q.sync2.enc_a, s_q.sync2.enc_b} == phase);
		apb_done = psel & penable & s_q.pready;
		wr = apb_done & pwrite;
		full = (s_q.level == DEPTH[AW:0]);
		empty = (s_q.level == '0);
	end

	// ************************************************
	// next state
	// ************************************************
	always_comb begin
		logic push, pop, arm_rise, clr_ovr;
		logic [CW-1:0] push_data;
		logic [CW-1:0] cnt;
		push = 1'b0;
		pop = 1'b0;
		push_data = '0;
		arm_rise = 1'b0;
		clr_ovr = 1'b0;
		cnt = '0;
		s_d = s_q;

		// two stages before anything looks at a pin
		s_d.sync1 = pins;
		s_d.sync2 = s_q.sync1;
		s_d.prev = s_q.sync2;

		// apb: one wait state, data and error loaded with pready
		s_d.pready = psel & penable & ~s_q.pready;
		if (psel & penable & ~s_q.pready) begin
			s_d.pslverr = 1'b0;
			case (paddr)
				REG_CTRL: s_d.prdata = 32'(s_q.ctrl);
				REG_RELOAD: s_d.prdata = 32'(s_q.reload);
				REG_COUNT: s_d.prdata = 32'(s_q.count);
				REG_STATUS: s_d.prdata = 32'({s_q.lost, empty, full, s_q.done, s_q.overrun});
				REG_RESULT: s_d.prdata = 32'(s_q.result);
				default: begin
					s_d.prdata = 32'h0000_0000;
					s_d.pslverr = 1'b1;
				end
			endcase
		end
		if (wr) begin
			case (paddr)
				REG_CTRL: begin
					s_d.ctrl = pwdata[CTRL_W-1:0];
					arm_rise = pwdata[CTRL_ARM] & ~s_q.ctrl[CTRL_ARM];
				end
				REG_RELOAD: s_d.reload = pwdata[CW-1:0];
				REG_STATUS: clr_ovr = pwdata[STAT_OVERRUN];
				default: begin
				end
			endcase
		end

		if (arm_rise) begin
			// a new arm starts every measurement from zero
			s_d.count = '0;
			s_d.done = 1'b0;
			s_d.pending = 1'b0;
			s_d.seen_start = 1'b0;
			s_d.seen_gate = 1'b0;
			s_d.sep = ES_WAIT_START;
		end else if (!armed) begin
			s_d.sep = ES_IDLE;
		end else if (!sep_func) begin
			// ************************************************
			// position
			// ************************************************
			cnt = s_q.count;
			if (step[1])
				cnt = step[0] ? s_q.count + 1'b1 : s_q.count - 1'b1;
			// step first, reload last, so a coincident step is overwritten
			if (reload_hit)
				cnt = s_q.reload;
			s_d.count = cnt;
			if (bufpos && samp_edge) begin
				push = 1'b1;
				push_data = s_q.count;
			end
		end else begin
			// ************************************************
			// edge separation
			// ************************************************
			if (start_edge)
				s_d.seen_start = 1'b1;
			if (gate_edge)
				s_d.seen_gate = 1'b1;
			case (s_q.sep)
				ES_WAIT_START: begin
					if (start_edge) begin
						s_d.count = '0;
						s_d.sep = ES_COUNT;
					end
				end
				ES_COUNT: begin
					// further start edges fall through untouched here
					if (gate_edge) begin
						s_d.result = s_q.count;
						if (smode == SEP_SAMPLED) begin
							s_d.pending = 1'b1;
							s_d.pend_val = s_q.count;
						end else begin
							push = 1'b1;
							push_data = s_q.count;
						end
						if (smode == SEP_SINGLE) begin
							s_d.done = 1'b1;
							s_d.sep = ES_DONE;
						end else begin
							s_d.sep = ES_REARM;
						end
					end else if (tb_edge) begin
						s_d.count = s_q.count + 1'b1;
					end
				end
				ES_REARM: begin
					if (gate_edge)
						s_d.sep = ES_WAIT_START;
				end
				ES_DONE: begin
				end
				default: s_d.sep = ES_IDLE;
			endcase
			if (smode == SEP_SAMPLED && samp_edge) begin
				if (s_q.pending) begin
					push = 1'b1;
					push_data = s_q.pend_val;
				end
				s_d.pending = 1'b0;
				s_d.seen_start = start_edge;
				s_d.seen_gate = gate_edge;
			end
		end

		// overrun: a set in the clearing cycle wins; disarm clears it
		if (clr_ovr || !armed)
			s_d.overrun = 1'b0;
		if (armed && sep_func && smode == SEP_SAMPLED && samp_edge &&
			!(s_q.seen_start && s_q.seen_gate))
			s_d.overrun = 1'b1;

		// ************************************************
		// fifo and stream
		// ************************************************
		pop = ~empty & (~s_q.svalid | stream_ready);
		if (pop) begin
			s_d.svalid = 1'b1;
			s_d.sdata = s_q.mem[s_q.rptr];
			s_d.rptr = s_q.rptr + 1'b1;
		end else if (stream_ready) begin
			s_d.svalid = 1'b0;
		end
		// a full fifo drops the value and marks it lost
		if (push && full)
			s_d.lost = 1'b1;
		else if (clr_ovr)
			s_d.lost = 1'b0;
		if (push && !full) begin
			s_d.mem[s_q.wptr] = push_data;
			s_d.wptr = s_q.wptr + 1'b1;
		end
		s_d.level = s_q.level + (AW+1)'(push & ~full) - (AW+1)'(pop);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
			s_q.ctrl <= CTRL_RESET;
			s_q.sep <= ES_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata = s_q.prdata;
	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign stream_valid = s_q.svalid;
	assign stream_data = s_q.sdata;

	// ************************************************
	// checks
	// ************************************************
	a_index_reload: assert property (@(posedge pclk) disable iff (!presetn)
		armed && !sep_func && reload_hit && !wr |=> s_q.count == $past(s_q.reload))
		else $error("index reload not applied");
	a_twopulse_up: assert property (@(posedge pclk) disable iff (!presetn)
		armed && !sep_func && dec == two_pulse_decoding && step == 2'h3 && !wr
		|=> s_q.count == $past(s_q.count) + 1'b1)
		else $error("two-pulse increment wrong");
	a_twopulse_down: assert property (@(posedge pclk) disable iff (!presetn)
		armed && !sep_func && dec == two_pulse_decoding && step == 2'h2 && !wr
		|=> s_q.count == $past(s_q.count) - 1'b1)
		else $error("two-pulse decrement wrong");
	a_unarmed_still: assert property (@(posedge pclk) disable iff (!presetn)
		!armed && !wr |=> $stable(s_q.count))
		else $error("count moved while not armed");
	a_start_ignored: assert property (@(posedge pclk) disable iff (!presetn)
		armed && sep_func && s_q.sep == ES_COUNT && !gate_edge && !tb_edge && !wr
		|=> $stable(s_q.count) && s_q.sep == ES_COUNT)
		else $error("count changed without timebase edge");
	a_gate_stores: assert property (@(posedge pclk) disable iff (!presetn)
		armed && sep_func && s_q.sep == ES_COUNT && gate_edge && !wr
		|=> s_q.result == $past(s_q.count) && s_q.sep != ES_COUNT)
		else $error("gate edge did not store count");
	a_single_holds: assert property (@(posedge pclk) disable iff (!presetn)
		armed && s_q.sep == ES_DONE && !wr |=> s_q.sep == ES_DONE ##1 s_q.done)
		else $error("single measurement restarted");
	a_overrun_set: assert property (@(posedge pclk) disable iff (!presetn)
		armed && sep_func && smode == SEP_SAMPLED && samp_edge && !s_q.seen_gate && !wr
		|=> s_q.overrun)
		else $error("overrun not flagged");
	a_overrun_keep: assert property (@(posedge pclk) disable iff (!presetn)
		s_q.overrun && armed && !wr |=> s_q.overrun)
		else $error("overrun lost without clear");
	a_sample_push: assert property (@(posedge pclk) disable iff (!presetn)
		armed && !sep_func && bufpos && samp_edge && empty && !s_q.svalid && !wr
		|=> s_q.level == 1 ##1 s_q.svalid && s_q.sdata == $past(s_q.count, 2))
		else $error("sample capture not streamed");
endmodule : eesc_counter

/* File: tb/eesc_far.sv */
/*
 * far side of the counter: encoder and signal pins, and a host sink that stalls.
 * assumes the bench calls the pin tasks from one process at a time.
 */
`timescale 1ns/10ps
module eesc_far (
	input wire logic pclk,
	output eesc_pkg::eesc_pins_t pins,
	output logic stream_ready,
	input wire logic stream_valid,
	input wire logic [31:0] stream_data
);
	import eesc_pkg::*;
	logic [31:0] got[$];
	logic [1:0] ph;
	initial begin
		pins = '0;
		stream_ready = 1'b0;
		ph = 2'h0;
	end
	// ************
	// host sink
	// ************
	// ready one cycle in three, so words must wait in the fifo
	always @(posedge pclk) begin
		if (stream_valid && stream_ready) begin
			got.push_back(stream_data);
		end
		ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
		stream_ready <= (ph == 2'h2);
	end
	// ************
	// pins
	// ************
	// one level change, held five cycles so the synchronisers see it
	task automatic hit(input int b);
		@(posedge pclk);
		pins[b] <= ~pins[b];
		repeat (4) @(posedge pclk);
	endtask : hit
	// n encoder cycles; two-pulse moves one channel only
	task automatic turn(input logic tp, input logic rev, input int n);
		int x;
		int y;
		x = rev ? 5 : 6;
		y = tp ? x : (rev ? 6 : 5);
		repeat (n) begin
			hit(x);
			hit(y);
			hit(x);
			hit(y);
		end
	endtask : turn
endmodule : eesc_far

/* File: tb/eesc_counter_tb.sv */
/*
 * self-checking bench of the counter: apb master, encoder and signal stimulus.
 * assumes the far-side model eesc_far and the package eesc_pkg.
 */
`timescale 1ns/10ps
module eesc_counter_tb;
	import eesc_pkg::*;
	typedef struct packed {
		logic [1:0] dec;
		logic rev;
		logic [3:0] n;
		logic [31:0] exp;
	} eesc_row_t;
	logic pclk;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic [31:0] stream_data;
	logic pready;
	logic pslverr;
	logic stream_valid;
	logic stream_ready;
	eesc_pins_t pins;
	logic [31:0] rd;
	logic err;
	int num_errors = 0;
	int n_checks = 0;
	int cycles = 0;
	eesc_row_t rows[8] = '{'{2'h0, 1'b0, 4'h2, 32'h2}, '{2'h0, 1'b1, 4'h2, 32'hfffffffe},
		'{2'h1, 1'b0, 4'h2, 32'h4}, '{2'h1, 1'b1, 4'h1, 32'hfffffffe},
		'{2'h2, 1'b0, 4'h2, 32'h8}, '{2'h2, 1'b1, 4'h1, 32'hfffffffc},
		'{2'h3, 1'b0, 4'h1, 32'h2}, '{2'h3, 1'b1, 4'h1, 32'hfffffffe}};
	always #12.5 pclk = ~pclk;
	eesc_counter #(.CW(32), .DEPTH(8)) i_eesc_counter (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
		.stream_valid(stream_valid), .stream_data(stream_data), .stream_ready(stream_ready));
	eesc_far i_eesc_far (.pclk(pclk), .pins(pins), .stream_ready(stream_ready),
		.stream_valid(stream_valid), .stream_data(stream_data));
	// ************
	// tasks
	// ************
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// the request stands until pready is seen high at a rising edge; data is taken there
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rdchk(input string w, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(w, e, rd);
	endtask : rdchk
	// disarm first so the arm bit sees a rising edge
	task automatic arm(input logic [31:0] cfg);
		apb(1'b1, REG_CTRL, 32'h0);
		apb(1'b1, REG_CTRL, cfg | 32'h1);
		i_eesc_far.got.delete();
	endtask : arm
	task automatic qchk(input string w, input int i, input logic [31:0] e);
		repeat (30) @(posedge pclk);
		chk(w, e, (i_eesc_far.got.size() > i) ? i_eesc_far.got[i] : 32'hxxxxxxxx);
	endtask : qchk
	task automatic ticks(input int n);
		repeat (n) begin
			i_eesc_far.hit(1);
			i_eesc_far.hit(1);
		end
	endtask : ticks
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : conclude
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			conclude();
		end
	end
	// ************
	// tests
	// ************
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rdchk("ctrl", REG_CTRL, 32'h0);
		rdchk("status", REG_STATUS, 32'h8);
		apb(1'b1, REG_COUNT, 32'h1234);
		i_eesc_far.turn(1'b0, 1'b0, 1);
		rdchk("count idle", REG_COUNT, 32'h0);
		rdchk("unmapped", 8'h20, 32'h0);
		chk("slverr", 32'h1, {31'h0, err});
		$display("test reset done");
		foreach (rows[i]) begin
			arm({28'h0, rows[i].dec, 2'b00});
			i_eesc_far.turn(rows[i].dec == two_pulse_decoding, rows[i].rev, 32'(rows[i].n));
			rdchk("count", REG_COUNT, rows[i].exp);
		end
		$display("test decoding done");
		// quad decoding, index reload in phase 00
		apb(1'b1, REG_RELOAD, 32'h55);
		arm(32'h208);
		i_eesc_far.hit(6);
		i_eesc_far.hit(5);
		i_eesc_far.hit(6);
		i_eesc_far.hit(4);
		rdchk("no reload", REG_COUNT, 32'h3);
		i_eesc_far.hit(5);
		i_eesc_far.hit(4);
		i_eesc_far.hit(6);
		rdchk("reload", REG_COUNT, 32'h56);
		// bring channel a back low so the next test starts from phase 00
		i_eesc_far.hit(6);
		$display("test reload done");
		// buffered quad position, sampled on the falling edge
		arm(32'h2018);
		i_eesc_far.hit(0);
		i_eesc_far.turn(1'b0, 1'b0, 1);
		i_eesc_far.hit(0);
		i_eesc_far.turn(1'b0, 1'b0, 1);
		i_eesc_far.hit(0);
		i_eesc_far.hit(0);
		qchk("sample 1", 0, 32'h4);
		qchk("sample 2", 1, 32'h8);
		$display("test buffered position done");
		// implicit buffered separation, all edges rising
		arm(32'h22);
		i_eesc_far.hit(3);
		ticks(3);
		i_eesc_far.hit(3);
		i_eesc_far.hit(3);
		ticks(2);
		i_eesc_far.hit(2);
		qchk("interval 1", 0, 32'h5);
		i_eesc_far.hit(2);
		i_eesc_far.hit(2);
		i_eesc_far.hit(3);
		i_eesc_far.hit(3);
		ticks(1);
		i_eesc_far.hit(2);
		i_eesc_far.hit(2);
		qchk("interval 2", 1, 32'h1);
		$display("test implicit done");
		// single separation, all edges falling; later edges must be ignored
		arm(32'h1c02);
		i_eesc_far.hit(3);
		ticks(2);
		i_eesc_far.hit(2);
		i_eesc_far.hit(3);
		i_eesc_far.hit(3);
		ticks(3);
		i_eesc_far.hit(2);
		i_eesc_far.hit(2);
		rdchk("single result", REG_RESULT, 32'h2);
		rdchk("single done", REG_STATUS, 32'ha);
		$display("test single done");
		// sample-clocked separation, then a sample period with no edges
		arm(32'h42);
		i_eesc_far.hit(3);
		ticks(3);
		i_eesc_far.hit(2);
		chk("held", 32'h0, 32'(i_eesc_far.got.size()));
		i_eesc_far.hit(0);
		qchk("sampled", 0, 32'h3);
		rdchk("no overrun", REG_STATUS, 32'h8);
		i_eesc_far.hit(0);
		i_eesc_far.hit(0);
		rdchk("overrun", REG_STATUS, 32'h9);
		apb(1'b1, REG_STATUS, 32'h1);
		rdchk("overrun cleared", REG_STATUS, 32'h8);
		i_eesc_far.hit(0);
		i_eesc_far.hit(0);
		rdchk("overrun again", REG_STATUS, 32'h9);
		apb(1'b1, REG_CTRL, 32'h0);
		rdchk("overrun disarmed", REG_STATUS, 32'h8);
		$display("test sampled done");
		// second reset in mid-run, with pins left away from idle
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		chk("valid after reset", 32'h0, {31'h0, stream_valid});
		rdchk("ctrl after reset", REG_CTRL, 32'h0);
		rdchk("status after reset", REG_STATUS, 32'h8);
		$display("test second reset done");
		conclude();
	end
endmodule : eesc_counter_tb
